// ==== bank_source_pkg.sv ====
package bank_source_pkg;

  localparam int NUM_BANKS   = 7;
  localparam int NUM_DRIVERS = 7;
  localparam int ADDR_W      = 12;
  localparam int DATA_W      = 32;
  localparam int WORD_LSB    = 2;
  localparam int REGION_LSB  = 5;

  // register byte offsets
  localparam logic [11:0] BANK_CFG_BASE = 12'h000;
  localparam logic [11:0] DRV_CFG_BASE  = 12'h020;
  localparam logic [11:0] GLOBAL_CFG    = 12'h040;
  localparam logic [11:0] STATUS        = 12'h044;

  // bank and driver configuration fields
  localparam int REG_OFF_BIT = 5;
  localparam int PASS_MSB    = 4;
  localparam int PASS_LSB    = 3;
  localparam int SRC_MSB     = 2;
  localparam int SRC_LSB     = 0;
  localparam int DRV_OFF_BIT = 7;

  // global configuration fields
  localparam int G_PASS0 = 0;
  localparam int G_PASS1 = 1;
  localparam int G_DIR0  = 2;
  localparam int G_DIR1  = 3;
  localparam int G_W     = 4;

  localparam logic [1:0] PASS_NORMAL = 2'h0;
  localparam logic [1:0] PASS_IN0    = 2'h1;
  localparam logic [1:0] PASS_IN1    = 2'h2;

  localparam logic [2:0] SEL_INT0_IN1DIV = 3'h0;
  localparam logic [2:0] SEL_INT1_REFDIV = 3'h1;
  localparam logic [2:0] SEL_INT2        = 3'h2;
  localparam logic [2:0] SEL_INT3        = 3'h3;
  localparam logic [2:0] SEL_FRAC0       = 3'h4;
  localparam logic [2:0] SEL_FRAC1       = 3'h5;
  localparam logic [2:0] SEL_FRAC2       = 3'h6;
  localparam logic [2:0] SEL_IN0DIV      = 3'h7;
  localparam logic [2:0] SRC_RESET       = SEL_FRAC1;

  // one bit per bank where a source is reachable
  localparam logic [6:0] INT0_BANKS   = 7'h03;
  localparam logic [6:0] IN1DIV_BANKS = 7'h70;
  localparam logic [6:0] INT1_BANKS   = 7'h07;
  localparam logic [6:0] REFDIV_BANKS = 7'h20;
  localparam logic [6:0] INT2_BANKS   = 7'h70;
  localparam logic [6:0] INT3_BANKS   = 7'h60;
  localparam logic [6:0] FRAC0_BANKS  = 7'h0f;
  localparam logic [6:0] FRAC1_BANKS  = 7'h7f;
  localparam logic [6:0] FRAC2_BANKS  = 7'h78;
  localparam logic [6:0] IN0DIV_BANKS = 7'h70;
  localparam logic [6:0] PASS_BANKS   = 7'h70;

  typedef enum logic [3:0] {
    src_reserved,
    src_integer_divider_0,
    src_integer_divider_1,
    src_integer_divider_2,
    src_integer_divider_3,
    src_fractional_divider_0,
    src_fractional_divider_1,
    src_fractional_divider_2,
    src_input0_divided_clock,
    src_input1_divided_clock,
    src_crystal_reference_divided,
    src_clock_input_0,
    src_clock_input_1
  } source_t;

endpackage

// ==== bank_source_decode.sv ====
`timescale 1ns/1ps
module bank_source_decode #(
  parameter int BANK = 0
) (
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     sys_rst,
  // bank controls
  input  wire logic [2:0]               source_code,
  input  wire logic [1:0]               passthrough_mode,
  input  wire logic                     input0_direct_active,
  input  wire logic                     input1_direct_active,
  // resolved source
  output bank_source_pkg::source_t      bank_source
);

  function automatic bank_source_pkg::source_t map_code(input logic [2:0] code);
    map_code = bank_source_pkg::src_reserved;
    unique case (code)
      bank_source_pkg::SEL_INT0_IN1DIV: begin
        if (bank_source_pkg::INT0_BANKS[BANK])
          map_code = bank_source_pkg::src_integer_divider_0;
        else if (bank_source_pkg::IN1DIV_BANKS[BANK])
          map_code = bank_source_pkg::src_input1_divided_clock;
      end
      bank_source_pkg::SEL_INT1_REFDIV: begin
        if (bank_source_pkg::INT1_BANKS[BANK])
          map_code = bank_source_pkg::src_integer_divider_1;
        else if (bank_source_pkg::REFDIV_BANKS[BANK])
          map_code = bank_source_pkg::src_crystal_reference_divided;
      end
      bank_source_pkg::SEL_INT2: begin
        if (bank_source_pkg::INT2_BANKS[BANK])
          map_code = bank_source_pkg::src_integer_divider_2;
      end
      bank_source_pkg::SEL_INT3: begin
        if (bank_source_pkg::INT3_BANKS[BANK])
          map_code = bank_source_pkg::src_integer_divider_3;
      end
      bank_source_pkg::SEL_FRAC0: begin
        if (bank_source_pkg::FRAC0_BANKS[BANK])
          map_code = bank_source_pkg::src_fractional_divider_0;
      end
      bank_source_pkg::SEL_FRAC1: begin
        if (bank_source_pkg::FRAC1_BANKS[BANK])
          map_code = bank_source_pkg::src_fractional_divider_1;
      end
      bank_source_pkg::SEL_FRAC2: begin
        if (bank_source_pkg::FRAC2_BANKS[BANK])
          map_code = bank_source_pkg::src_fractional_divider_2;
      end
      bank_source_pkg::SEL_IN0DIV: begin
        if (bank_source_pkg::IN0DIV_BANKS[BANK])
          map_code = bank_source_pkg::src_input0_divided_clock;
      end
    endcase
  endfunction

  localparam logic PASS_OK = bank_source_pkg::PASS_BANKS[BANK];

  bank_source_pkg::source_t next_bank_source;

  always_comb begin
    next_bank_source = map_code(source_code);
    // low banks have no passthrough path at all
    if (PASS_OK) begin
      if (passthrough_mode == bank_source_pkg::PASS_IN0 && input0_direct_active)
        next_bank_source = bank_source_pkg::src_clock_input_0;
      else if (passthrough_mode == bank_source_pkg::PASS_IN1 && input1_direct_active)
        next_bank_source = bank_source_pkg::src_clock_input_1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      bank_source <= bank_source_pkg::src_fractional_divider_1;
    else
      bank_source <= next_bank_source;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  direct_needs_pass_a: assert property (
    bank_source == bank_source_pkg::src_clock_input_0 |->
      PASS_OK && $past(input0_direct_active) &&
      $past(passthrough_mode) == bank_source_pkg::PASS_IN0)
    else $error("input 0 passthrough without its enable");

  input1_direct_a: assert property (
    PASS_OK && passthrough_mode == bank_source_pkg::PASS_IN1 && input1_direct_active |=>
      bank_source == bank_source_pkg::src_clock_input_1)
    else $error("input 1 passthrough not taken");

  low_bank_pass_a: assert property (
    !PASS_OK |-> bank_source != bank_source_pkg::src_clock_input_0 &&
      bank_source != bank_source_pkg::src_clock_input_1)
    else $error("passthrough on a bank without it");

  normal_mode_a: assert property (
    passthrough_mode == bank_source_pkg::PASS_NORMAL |=>
      bank_source == map_code($past(source_code)))
    else $error("normal mode source mismatch");

  frac1_all_a: assert property (
    passthrough_mode == bank_source_pkg::PASS_NORMAL &&
      source_code == bank_source_pkg::SEL_FRAC1 |=>
      bank_source == bank_source_pkg::src_fractional_divider_1)
    else $error("code 0x5 does not give fractional divider 1");

endmodule

// ==== output_bank_source_select.sv ====
`timescale 1ns/1ps
module output_bank_source_select (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    sys_rst,
  // apb slave
  input  wire logic [11:0]             paddr,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // bank controls
  output logic      [6:0]              bank_regulator_off,
  output bank_source_pkg::source_t     bank_source [bank_source_pkg::NUM_BANKS],
  // driver controls
  output logic      [6:0]              driver_power_off
);

  localparam int NB = bank_source_pkg::NUM_BANKS;
  localparam int ND = bank_source_pkg::NUM_DRIVERS;

  function automatic logic in_region(input logic [11:0] addr, input logic [11:0] base,
                                     input int count);
    in_region = (addr[11:bank_source_pkg::REGION_LSB] ==
                 base[11:bank_source_pkg::REGION_LSB]) &&
                (int'(addr[bank_source_pkg::REGION_LSB-1:bank_source_pkg::WORD_LSB]) < count);
  endfunction

  logic [1:0]             passthrough_mode [NB];
  logic [2:0]             source_code      [NB];
  logic [3:0]             global_cfg;
  logic [31:0]            next_prdata;
  logic                   next_slverr;
  logic                   access;
  logic                   commit;
  logic                   bank_hit;
  logic                   drv_hit;
  logic [2:0]             word_idx;
  logic [NB-1:0]          bank_reserved;
  logic                   input0_direct_active;
  logic                   input1_direct_active;

  assign access   = psel && penable;
  // one wait state: the write lands on the edge where pready is seen high
  assign commit   = access && pready;
  assign word_idx = paddr[bank_source_pkg::REGION_LSB-1:bank_source_pkg::WORD_LSB];
  assign bank_hit = in_region(paddr, bank_source_pkg::BANK_CFG_BASE, NB);
  assign drv_hit  = in_region(paddr, bank_source_pkg::DRV_CFG_BASE, ND);

  // fan-out needs both the global enable and the direct flag of its input
  assign input0_direct_active = global_cfg[bank_source_pkg::G_PASS0] &&
                                global_cfg[bank_source_pkg::G_DIR0];
  assign input1_direct_active = global_cfg[bank_source_pkg::G_PASS1] &&
                                global_cfg[bank_source_pkg::G_DIR1];

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= access && !pready;
      prdata  <= (access && !pready && !pwrite) ? next_prdata : 32'h0000_0000;
      pslverr <= access && !pready && next_slverr;
    end
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    next_slverr = 1'b0;
    if (bank_hit) begin
      next_prdata[bank_source_pkg::REG_OFF_BIT] = bank_regulator_off[word_idx];
      next_prdata[bank_source_pkg::PASS_MSB:bank_source_pkg::PASS_LSB] =
        passthrough_mode[word_idx];
      next_prdata[bank_source_pkg::SRC_MSB:bank_source_pkg::SRC_LSB] = source_code[word_idx];
    end else if (drv_hit) begin
      next_prdata[bank_source_pkg::DRV_OFF_BIT] = driver_power_off[word_idx];
    end else if (paddr == bank_source_pkg::GLOBAL_CFG) begin
      next_prdata[bank_source_pkg::G_W-1:0] = global_cfg;
    end else if (paddr == bank_source_pkg::STATUS) begin
      next_prdata[NB-1:0] = bank_reserved;
    end else begin
      next_slverr = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      global_cfg <= 4'h0;
    else if (commit && pwrite && paddr == bank_source_pkg::GLOBAL_CFG)
      global_cfg <= pwdata[bank_source_pkg::G_W-1:0];
  end

  genvar b;
  generate
    for (b = 0; b < NB; b++) begin : g_bank
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          bank_regulator_off[b] <= 1'b0;
          passthrough_mode[b]   <= bank_source_pkg::PASS_NORMAL;
          source_code[b]        <= bank_source_pkg::SRC_RESET;
        end else if (commit && pwrite && bank_hit && int'(word_idx) == b) begin
          bank_regulator_off[b] <= pwdata[bank_source_pkg::REG_OFF_BIT];
          passthrough_mode[b]   <=
            pwdata[bank_source_pkg::PASS_MSB:bank_source_pkg::PASS_LSB];
          source_code[b]        <=
            pwdata[bank_source_pkg::SRC_MSB:bank_source_pkg::SRC_LSB];
        end
      end

      bank_source_decode #(
        .BANK (b)
      ) u_decode (
        .sys_clk              (sys_clk),
        .sys_rst              (sys_rst),
        .source_code          (source_code[b]),
        .passthrough_mode     (passthrough_mode[b]),
        .input0_direct_active (input0_direct_active),
        .input1_direct_active (input1_direct_active),
        .bank_source          (bank_source[b])
      );

      // software is not meant to program these, so flag them for it to see
      assign bank_reserved[b] = (bank_source[b] == bank_source_pkg::src_reserved);
    end

    for (b = 0; b < ND; b++) begin : g_drv
      always_ff @(posedge sys_clk) begin
        if (sys_rst)
          driver_power_off[b] <= 1'b0;
        else if (commit && pwrite && drv_hit && int'(word_idx) == b)
          driver_power_off[b] <= pwdata[bank_source_pkg::DRV_OFF_BIT];
      end
    end
  endgenerate

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  regulator_write_a: assert property (
    commit && pwrite && bank_hit && word_idx == 3'h0 |=>
      bank_regulator_off[0] == $past(pwdata[bank_source_pkg::REG_OFF_BIT]))
    else $error("bank 0 regulator control not written");

  driver_write_a: assert property (
    commit && pwrite && drv_hit && word_idx == 3'h6 |=>
      driver_power_off[6] == $past(pwdata[bank_source_pkg::DRV_OFF_BIT]))
    else $error("driver 6 power control not written");

  reset_source_a: assert property (
    $fell(sys_rst) |-> source_code[4] == bank_source_pkg::SRC_RESET &&
      bank_source[4] == bank_source_pkg::src_fractional_divider_1)
    else $error("bank 4 source not at reset value");

  hold_no_write_a: assert property (
    !(commit && pwrite) |=> $stable(source_code[5]) && $stable(passthrough_mode[5]) &&
      $stable(bank_regulator_off[5]))
    else $error("bank 5 controls changed without a write");

  int0_bank0_a: assert property (
    source_code[0] == bank_source_pkg::SEL_INT0_IN1DIV |=>
      bank_source[0] == bank_source_pkg::src_integer_divider_0)
    else $error("bank 0 code 0x0 not integer divider 0");

  refdiv_bank5_a: assert property (
    source_code[5] == bank_source_pkg::SEL_INT1_REFDIV &&
      passthrough_mode[5] == bank_source_pkg::PASS_NORMAL |=>
      bank_source[5] == bank_source_pkg::src_crystal_reference_divided)
    else $error("bank 5 code 0x1 not divided reference");

  int3_bank6_a: assert property (
    source_code[6] == bank_source_pkg::SEL_INT3 &&
      passthrough_mode[6] == bank_source_pkg::PASS_NORMAL |=>
      bank_source[6] == bank_source_pkg::src_integer_divider_3)
    else $error("bank 6 code 0x3 not integer divider 3");

  frac2_bank3_a: assert property (
    source_code[3] == bank_source_pkg::SEL_FRAC2 |=>
      bank_source[3] == bank_source_pkg::src_fractional_divider_2)
    else $error("bank 3 code 0x6 not fractional divider 2");

  in0_direct_a: assert property (
    passthrough_mode[4] == bank_source_pkg::PASS_IN0 && input0_direct_active |=>
      bank_source[4] == bank_source_pkg::src_clock_input_0)
    else $error("bank 4 input 0 passthrough not taken");

  apb_answer_a: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not after one wait state");

  pass0_cover_c: cover property (
    passthrough_mode[4] == bank_source_pkg::PASS_IN0 && input0_direct_active ##1
      bank_source[4] == bank_source_pkg::src_clock_input_0);
  pass1_cover_c: cover property (
    bank_source[6] == bank_source_pkg::src_clock_input_1);
  power_down_cover_c: cover property (
    bank_regulator_off[2] && driver_power_off[2]);
  reserved_cover_c: cover property (bank_reserved != 7'h00);

endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [31:0] data;
    logic        err;
    logic        chk;
  } note_t;
  // clock and reset
  logic                     sys_clk;
  logic                     sys_rst;
  // apb
  logic [11:0]              paddr;
  logic                     psel;
  logic                     penable;
  logic                     pwrite;
  logic [31:0]              pwdata;
  logic [31:0]              prdata;
  logic                     pready;
  logic                     pslverr;
  // bank and driver controls
  logic [6:0]               bank_regulator_off;
  bank_source_pkg::source_t bank_source [bank_source_pkg::NUM_BANKS];
  logic [6:0]               driver_power_off;
  // bench state
  note_t                    notes [$];
  note_t                    n;
  int                       errors;
  int                       samples_checked;
  int                       cycles;
  logic [2:0]               m_code [7];
  logic [1:0]               m_pass [7];
  logic [6:0]               m_reg;
  logic [6:0]               m_drv;
  logic [3:0]               m_g;
  logic [31:0]              v;

  output_bank_source_select uut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bank_regulator_off(bank_regulator_off), .bank_source(bank_source),
    .driver_power_off(driver_power_off)
  );

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // expected source worked out from the mapping, independent of the design's masks
  // mux clock gates sit outside this block; enabling only the chosen source is software's job
  function automatic bank_source_pkg::source_t exp_src(int b, logic [2:0] c, logic [1:0] p,
                                                        logic [3:0] g);
    if (b >= 4 && p == 2'h1 && g[0] && g[2]) return bank_source_pkg::src_clock_input_0;
    if (b >= 4 && p == 2'h2 && g[1] && g[3]) return bank_source_pkg::src_clock_input_1;
    case (c)
      3'h0: if (b <= 1) return bank_source_pkg::src_integer_divider_0;
            else if (b >= 4) return bank_source_pkg::src_input1_divided_clock;
      3'h1: if (b <= 2) return bank_source_pkg::src_integer_divider_1;
            else if (b == 5) return bank_source_pkg::src_crystal_reference_divided;
      3'h2: if (b >= 4) return bank_source_pkg::src_integer_divider_2;
      3'h3: if (b >= 5) return bank_source_pkg::src_integer_divider_3;
      3'h4: if (b <= 3) return bank_source_pkg::src_fractional_divider_0;
      3'h5: return bank_source_pkg::src_fractional_divider_1;
      3'h6: if (b >= 3) return bank_source_pkg::src_fractional_divider_2;
      default: if (b >= 4) return bank_source_pkg::src_input0_divided_clock;
    endcase
    return bank_source_pkg::src_reserved;
  endfunction

  function automatic logic [31:0] exp_status();
    logic [31:0] s;
    s = 32'h0;
    for (int b = 0; b < 7; b++) begin
      s[b] = (exp_src(b, m_code[b], m_pass[b], m_g) == bank_source_pkg::src_reserved);
    end
    return s;
  endfunction

  task automatic fail(input string what);
    errors++;
    $display("CHECK FAILED %0t %s", $time, what);
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) fail($sformatf("%s got %h exp %h", what, got, exp));
  endtask

  task automatic cmp_flag(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) fail($sformatf("%s got %b exp %b", what, got, exp));
  endtask

  task automatic cmp_src(input bank_source_pkg::source_t got,
                         input bank_source_pkg::source_t exp, input int b);
    samples_checked++;
    if (got !== exp) fail($sformatf("bank %0d source got %0d exp %0d", b, got, exp));
  endtask

  // one apb transfer; the expected answer is noted before the request goes out
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     input logic [31:0] ed, input logic ee, input logic chk);
    notes.push_back('{data: ed, err: ee, chk: chk});
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic ee);
    apb(a, 1'b1, d, 32'h0, ee, 1'b0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic ee);
    apb(a, 1'b0, 32'h0, ed, ee, 1'b1);
  endtask

  task automatic check_outputs();
    repeat (2) @(posedge sys_clk);
    for (int b = 0; b < 7; b++) cmp_src(bank_source[b], exp_src(b, m_code[b], m_pass[b], m_g), b);
    cmp_word({25'h0, bank_regulator_off}, {25'h0, m_reg}, "regulator off");
    cmp_word({25'h0, driver_power_off}, {25'h0, m_drv}, "driver off");
  endtask

  task automatic check_defaults();
    for (int b = 0; b < 7; b++) begin
      m_code[b] = 3'h5;
      m_pass[b] = 2'h0;
    end
    m_reg = 7'h0;
    m_drv = 7'h0;
    m_g   = 4'h0;
    check_outputs();
    for (int b = 0; b < 7; b++) begin
      rd(bank_source_pkg::BANK_CFG_BASE + 12'(4 * b), 32'h5, 1'b0);
      rd(bank_source_pkg::DRV_CFG_BASE + 12'(4 * b), 32'h0, 1'b0);
    end
    rd(bank_source_pkg::GLOBAL_CFG, 32'h0, 1'b0);
  endtask

  // answers are compared at the edge where pready is sampled high
  always @(posedge sys_clk) begin
    if (!sys_rst && psel && penable && pready === 1'b1) begin
      if (notes.size() == 0) begin
        fail("answer without request");
      end else begin
        n = notes.pop_front();
        cmp_flag(pslverr, n.err, "pslverr");
        if (n.chk) cmp_word(prdata, n.data, "prdata");
      end
    end
  end

  task automatic final_report();
    if (errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // the sweep needs about 50k cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 90000) begin
      fail("timeout");
      final_report();
    end
  end

  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    errors = 0;
    samples_checked = 0;
    cycles = 0;
    void'($urandom(32'h6369));
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    check_defaults();
    // every global setting against every bank, code and passthrough mode
    for (int g = 0; g < 16; g++) begin
      v = $urandom;
      wr(bank_source_pkg::GLOBAL_CFG, {v[31:4], 4'(g)}, 1'b0);
      m_g = 4'(g);
      rd(bank_source_pkg::GLOBAL_CFG, {28'h0, 4'(g)}, 1'b0);
      for (int b = 0; b < 7; b++) begin
        for (int c = 0; c < 8; c++) begin
          for (int p = 0; p < 4; p++) begin
            v = $urandom;
            m_code[b] = 3'(c);
            m_pass[b] = 2'(p);
            m_reg[b]  = v[5];
            wr(bank_source_pkg::BANK_CFG_BASE + 12'(4 * b), {v[31:6], v[5], 2'(p), 3'(c)}, 1'b0);
            repeat (2) @(posedge sys_clk);
            cmp_src(bank_source[b], exp_src(b, 3'(c), 2'(p), m_g), b);
            cmp_flag(bank_regulator_off[b], v[5], "regulator off");
            rd(bank_source_pkg::BANK_CFG_BASE + 12'(4 * b), {26'h0, v[5], 2'(p), 3'(c)}, 1'b0);
            rd(bank_source_pkg::STATUS, exp_status(), 1'b0);
          end
        end
      end
      check_outputs();
    end
    for (int d = 0; d < 7; d++) begin
      v = $urandom;
      m_drv[d] = v[7];
      wr(bank_source_pkg::DRV_CFG_BASE + 12'(4 * d), v, 1'b0);
      rd(bank_source_pkg::DRV_CFG_BASE + 12'(4 * d), {24'h0, v[7], 7'h0}, 1'b0);
    end
    check_outputs();
    // bank 2 and driver 2 are each powered down by a write of their own
    v = $urandom;
    m_reg[2] = 1'b1;
    m_drv[2] = 1'b1;
    wr(bank_source_pkg::BANK_CFG_BASE + 12'h008, {v[31:6], 1'b1, m_pass[2], m_code[2]}, 1'b0);
    wr(bank_source_pkg::DRV_CFG_BASE + 12'h008, 32'h0000_0080, 1'b0);
    check_outputs();
    // unmapped places refuse and leave every control alone
    wr(12'h01c, 32'hffffffff, 1'b1);
    rd(12'h01c, 32'h0, 1'b1);
    wr(12'h03c, 32'hffffffff, 1'b1);
    rd(12'h03c, 32'h0, 1'b1);
    wr(12'h048, 32'hffffffff, 1'b1);
    wr(bank_source_pkg::STATUS, 32'hffffffff, 1'b0);
    rd(bank_source_pkg::STATUS, exp_status(), 1'b0);
    check_outputs();
    // reset in mid-run restores every default
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    check_defaults();
    final_report();
  end
endmodule
